// ==== inc/dscr_cfg.svh ====
/*
 * Offsets, field positions, reset values and timing counts for the decoder
 * status and configuration register bank.
 * Assumes a byte-addressed AXI4-Lite bus with 32-bit data and 8-bit address.
 */
// Contract
// R1 - Preview nibble below 8 gives mode 0..7 directly; top bit means >7 or error
// R2 - Preview top bit ORs mode bits 7..3 with erasure; low bits OR erasure
// R3 - Reading the decoder status register clears the pending decoder interrupt
// R4 - Status bit 7 reads 0 while interrupt registers valid, 1 once invalid
// R5 - Status bit 5 reads 1 once error correction ran on current block
// R6 - Any write to soft reset register reinitialises registers, data picks host mode; code ignores such writes unless write strobe bit 0 is set
// R7 - Host mode 000 compat A, 001 ATAPI, 010 compat B, 011 unknown host
// R8 - Hardware reset leaves host mode 111, device idles until mode written
// R9 - Unknown host setting keeps all host bus pins at high impedance; code still drives them while host read strobe is low
// R10 - After hardware reset pins stay high impedance unless host read strobe low
// R11 - Subcode block address holds 10 bits, inside the first kilobyte
// R12 - Input config bit 7 picks serial format: 0 I2S style, 1 EIAJ
// R13 - Input config bits 6,5 set oversampling: 00 none, 01 two, 10 four
// R14 - Input config bit 4 picks subcode format: 0 V4, 1 EIAJ
// R15 - Input config bit 3 switches the subcode interface on
// R16 - Input config bit 2 picks subcode: 0 cooked, 1 raw
// R17 - Input config bit 1 puts external buffer RAM into test mode
// R18 - Subcode recovery timed from bit clock divided by programmed oversampling
// R19 - Reserved and unused bits read zero and ignore writes
`ifndef DSCR_CFG_SVH
`define DSCR_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define DSCR_ADDR_PREVIEW    8'h00
`define DSCR_ADDR_STATUS     8'h04
`define DSCR_ADDR_SOFT_RESET 8'h08
`define DSCR_ADDR_SUB_ADDR   8'h0C
`define DSCR_ADDR_IN_CFG     8'h10

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define DSCR_STAT_INVALID_BIT 7
`define DSCR_STAT_ECC_BIT     5
`define DSCR_CFG_SERIAL_BIT   7
`define DSCR_CFG_OVS_HI_BIT   6
`define DSCR_CFG_OVS_LO_BIT   5
`define DSCR_CFG_SUBFMT_BIT   4
`define DSCR_CFG_SUBEN_BIT    3
`define DSCR_CFG_SUBRAW_BIT   2
`define DSCR_CFG_EXT_RAM_TEST_BIT  1
`define DSCR_CFG_WR_MASK      8'hFE
`define DSCR_SUB_ADDR_W       10

////////////////////////////////////////////////////////////////////////////////
// Reset values and AXI responses
`define DSCR_RST_CFG      8'h00
`define DSCR_RST_SUB_ADDR 10'h000
`define DSCR_RST_PREVIEW  4'h0
`define DSCR_RESP_OKAY    2'h0
`define DSCR_RESP_SLVERR  2'h2

////////////////////////////////////////////////////////////////////////////////
// Bit clock divide terminal counts per oversampling code
`define DSCR_DIV_NONE 2'h0
`define DSCR_DIV_TWO  2'h1
`define DSCR_DIV_FOUR 2'h3

`endif

// ==== inc/dscr_pkg.sv ====
/*
 * Types shared by the decoder status and configuration register bank.
 * Assumes dscr_cfg.svh is compiled alongside.
 */
package dscr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Host interface modes, 111 is the hardware reset value
   typedef enum logic [2:0] {
      DSCR_HOST_COMPAT_A = 3'h0,
      DSCR_HOST_ATAPI    = 3'h1,
      DSCR_HOST_COMPAT_B = 3'h2,
      DSCR_HOST_UNKNOWN  = 3'h3,
      DSCR_HOST_POWERUP  = 3'h7
   } dscr_host_e;

   // Register select result of the address decoder
   typedef enum logic [2:0] {
      DSCR_SEL_PREVIEW = 3'h0,
      DSCR_SEL_STATUS  = 3'h1,
      DSCR_SEL_SOFT    = 3'h3,
      DSCR_SEL_SUB     = 3'h2,
      DSCR_SEL_CFG     = 3'h6,
      DSCR_SEL_NONE    = 3'h7
   } dscr_sel_e;

   ////////////////////////////////////////////////////////////////////////////
   // Whole state of the register bank
   typedef struct packed {
      logic        aw_held;
      logic        w_held;
      logic [7:0]  waddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [3:0]  preview;
      logic        intr;
      logic        invalid;
      logic        ecc;
      logic [2:0]  host_mode;
      logic [9:0]  sub_addr;
      logic [7:0]  cfg;
      logic        hrd_s1;
      logic        hrd_s2;
      logic        bck_s1;
      logic        bck_s2;
      logic        bck_s3;
      logic [1:0]  div_cnt;
      logic        tick;
      logic        oe;
      logic        soft_pulse;
   } dscr_state_s;

endpackage

// ==== verilog/dscr_preview.sv ====
/*
 * Next-block mode preview encoder.
 * Assumes mode byte and erasure flag come from decoder logic on the same clock.
 */
module dscr_preview (
   input  wire logic [7:0] mode_byte_in,
   input  wire logic       erasure_flag_in,
   output logic      [3:0] preview_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Top bit flags modes above seven or an erased byte
   always_comb begin
      preview_out[3]   = (|mode_byte_in[7:3]) | erasure_flag_in;   // [R1] [R2]
      preview_out[2:0] = mode_byte_in[2:0] | {3{erasure_flag_in}}; // [R2]
   end

endmodule

// ==== verilog/dscr_regs.sv ====
/*
 * Decoder status and configuration register bank with AXI4-Lite slave,
 * host pin enable control and subcode bit clock divider.
 * Assumes decoder datapath inputs share clock_in; pins are raw asynchronous.
 */
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`include "dscr_cfg.svh"

module dscr_regs (
   input  wire logic        clock_in,
   input  wire logic        arst_n_in,
   // AXI4-Lite write address, data and response
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // AXI4-Lite read address and data
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // Decoder datapath
   input  wire logic [7:0]  mode_byte_in,
   input  wire logic        erasure_flag_in,
   input  wire logic        mode_byte_valid_in,
   input  wire logic        decoder_interrupt_set_in,
   input  wire logic        regs_invalid_set_in,
   input  wire logic        ecc_done_in,
   // Pins
   input  wire logic        host_read_strobe_n_in,
   input  wire logic        serial_bit_clock_in,
   // Control outputs
   output logic             decoder_interrupt_out,
   output logic [2:0]       host_mode_out,
   output logic             host_bus_oe_out,
   output logic             soft_reset_out,
   output logic [9:0]       subcode_block_address_out,
   output logic             serial_format_sel_out,
   output logic             oversample_hi_out,
   output logic             oversample_lo_out,
   output logic             subcode_format_sel_out,
   output logic             subcode_port_enable_out,
   output logic             subcode_raw_sel_out,
   output logic             ext_ram_test_out,
   output logic             subcode_bit_tick_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode shared by read and write paths
   function automatic dscr_pkg::dscr_sel_e reg_sel(input logic [7:0] addr);
      dscr_pkg::dscr_sel_e sel;
      sel = dscr_pkg::DSCR_SEL_NONE;
      if (addr == `DSCR_ADDR_PREVIEW) begin
         sel = dscr_pkg::DSCR_SEL_PREVIEW;
      end else if (addr == `DSCR_ADDR_STATUS) begin
         sel = dscr_pkg::DSCR_SEL_STATUS;
      end else if (addr == `DSCR_ADDR_SOFT_RESET) begin
         sel = dscr_pkg::DSCR_SEL_SOFT;
      end else if (addr == `DSCR_ADDR_SUB_ADDR) begin
         sel = dscr_pkg::DSCR_SEL_SUB;
      end else if (addr == `DSCR_ADDR_IN_CFG) begin
         sel = dscr_pkg::DSCR_SEL_CFG;
      end
      return sel;
   endfunction

   // Bit clock divide terminal count from oversampling field
   function automatic logic [1:0] div_limit(input logic [7:0] cfg);
      logic [1:0] lim;
      lim = `DSCR_DIV_NONE;
      if (cfg[`DSCR_CFG_OVS_HI_BIT:`DSCR_CFG_OVS_LO_BIT] == 2'h1) begin
         lim = `DSCR_DIV_TWO;
      end else if (cfg[`DSCR_CFG_OVS_HI_BIT:`DSCR_CFG_OVS_LO_BIT] == 2'h2) begin
         lim = `DSCR_DIV_FOUR;
      end
      return lim;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   logic rst_s1_q;
   logic rst_n_q;

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Preview encoder
   logic [3:0] preview_w;

   dscr_preview u_preview (
      .mode_byte_in    (mode_byte_in),
      .erasure_flag_in (erasure_flag_in),
      .preview_out     (preview_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // State
   dscr_pkg::dscr_state_s s_q;
   dscr_pkg::dscr_state_s s_d;
   dscr_pkg::dscr_sel_e   wsel;
   dscr_pkg::dscr_sel_e   rsel;
   logic                  do_write;
   logic                  do_read;
   logic                  stat_read;
   logic                  soft_wr;
   logic                  mode_known;
   logic                  bck_edge;

   // Next state of the whole bank
   always_comb begin
      s_d        = s_q;
      s_d.soft_pulse = 1'b0;
      s_d.tick   = 1'b0;
      do_write   = s_q.aw_held && s_q.w_held && !s_q.bvalid;
      do_read    = s_axi_arvalid_in && s_q.arready;
      wsel       = reg_sel(s_q.waddr);
      rsel       = reg_sel(s_axi_araddr_in);
      stat_read  = do_read && (rsel == dscr_pkg::DSCR_SEL_STATUS);
      soft_wr    = do_write && (wsel == dscr_pkg::DSCR_SEL_SOFT) && s_q.wstrb[0];
      mode_known = (s_q.host_mode == dscr_pkg::DSCR_HOST_COMPAT_A) ||
                   (s_q.host_mode == dscr_pkg::DSCR_HOST_ATAPI) ||
                   (s_q.host_mode == dscr_pkg::DSCR_HOST_COMPAT_B);
      bck_edge   = s_q.bck_s2 && !s_q.bck_s3;

      // Pin synchronisers
      s_d.hrd_s1 = host_read_strobe_n_in;
      s_d.hrd_s2 = s_q.hrd_s1;
      s_d.bck_s1 = serial_bit_clock_in;
      s_d.bck_s2 = s_q.bck_s1;
      s_d.bck_s3 = s_q.bck_s2;

      // Write address and data captured independently
      if (s_axi_awvalid_in && s_q.awready) begin
         s_d.aw_held = 1'b1;
         s_d.waddr   = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_q.wready) begin
         s_d.w_held = 1'b1;
         s_d.wdata  = s_axi_wdata_in;
         s_d.wstrb  = s_axi_wstrb_in;
      end
      if (s_q.bvalid && s_axi_bready_in) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.rvalid && s_axi_rready_in) begin
         s_d.rvalid = 1'b0;
      end

      // Datapath events; interrupt set placed after its status-read clear so it wins, but the invalid clear comes after its set and wins
      if (mode_byte_valid_in) begin
         s_d.preview = preview_w;                                  // [R1] [R2]
      end
      s_d.ecc = ecc_done_in;                                       // [R5]
      if (stat_read) begin
         s_d.intr = 1'b0;                                          // [R3]
      end
      if (regs_invalid_set_in) begin
         s_d.invalid = 1'b1;                                       // [R4]
      end
      if (decoder_interrupt_set_in) begin
         s_d.intr    = 1'b1;
         s_d.invalid = 1'b0;                                       // [R4]
      end

      // Register writes
      if (do_write) begin
         s_d.aw_held = 1'b0;
         s_d.w_held  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = `DSCR_RESP_OKAY;
         if (wsel == dscr_pkg::DSCR_SEL_NONE) begin
            s_d.bresp = `DSCR_RESP_SLVERR;
         end else if (soft_wr) begin
            s_d.cfg        = `DSCR_RST_CFG;                        // [R6]
            s_d.sub_addr   = `DSCR_RST_SUB_ADDR;
            s_d.preview    = `DSCR_RST_PREVIEW;
            s_d.intr       = 1'b0;
            s_d.invalid    = 1'b0;
            s_d.div_cnt    = 2'h0;
            s_d.host_mode  = s_q.wdata[2:0];                       // [R6] [R7]
            s_d.soft_pulse = 1'b1;
         end else if (wsel == dscr_pkg::DSCR_SEL_SUB) begin
            if (s_q.wstrb[0]) begin
               s_d.sub_addr[7:0] = s_q.wdata[7:0];                 // [R11]
            end
            if (s_q.wstrb[1]) begin
               s_d.sub_addr[9:8] = s_q.wdata[9:8];                 // [R11] [R19]
            end
         end else if (wsel == dscr_pkg::DSCR_SEL_CFG && s_q.wstrb[0]) begin
            s_d.cfg = s_q.wdata[7:0] & `DSCR_CFG_WR_MASK;          // [R19]
         end
      end

      // Read data; unused bits stay zero
      if (do_read) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = `DSCR_RESP_OKAY;
         s_d.rdata  = 32'h0000_0000;                               // [R19]
         if (rsel == dscr_pkg::DSCR_SEL_PREVIEW) begin
            s_d.rdata[3:0] = s_q.preview;
         end else if (rsel == dscr_pkg::DSCR_SEL_STATUS) begin
            s_d.rdata[`DSCR_STAT_INVALID_BIT] = s_q.invalid;       // [R4]
            s_d.rdata[`DSCR_STAT_ECC_BIT]     = s_q.ecc;           // [R5]
         end else if (rsel == dscr_pkg::DSCR_SEL_SUB) begin
            s_d.rdata[9:0] = s_q.sub_addr;
         end else if (rsel == dscr_pkg::DSCR_SEL_CFG) begin
            s_d.rdata[7:0] = s_q.cfg;
         end else if (rsel == dscr_pkg::DSCR_SEL_NONE) begin
            s_d.rresp = `DSCR_RESP_SLVERR;
         end
      end

      // Host pins driven only for a known host or a low read strobe
      s_d.oe = mode_known || !s_q.hrd_s2;                          // [R9] [R10]

      // Subcode bit tick: one per bit clock edge group of the oversample factor
      if (bck_edge) begin
         if (s_q.div_cnt >= div_limit(s_q.cfg)) begin              // [R18] [R13]
            s_d.div_cnt = 2'h0;
            s_d.tick    = s_q.cfg[`DSCR_CFG_SUBEN_BIT];            // [R15]
         end else begin
            s_d.div_cnt = s_q.div_cnt + 2'h1;
         end
      end

      // One item at a time per direction
      s_d.awready = !s_d.aw_held && !s_d.bvalid;
      s_d.wready  = !s_d.w_held && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;
   end

   // State register; host mode wakes at 111
   always_ff @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         s_q           <= '0;
         s_q.host_mode <= dscr_pkg::DSCR_HOST_POWERUP;             // [R8]
         s_q.hrd_s1    <= 1'b1;
         s_q.hrd_s2    <= 1'b1;
         s_q.cfg       <= `DSCR_RST_CFG;
         s_q.sub_addr  <= `DSCR_RST_SUB_ADDR;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from state
   assign s_axi_awready_out         = s_q.awready;
   assign s_axi_wready_out          = s_q.wready;
   assign s_axi_bvalid_out          = s_q.bvalid;
   assign s_axi_bresp_out           = s_q.bresp;
   assign s_axi_arready_out         = s_q.arready;
   assign s_axi_rvalid_out          = s_q.rvalid;
   assign s_axi_rresp_out           = s_q.rresp;
   assign s_axi_rdata_out           = s_q.rdata;
   assign decoder_interrupt_out     = s_q.intr;
   assign host_mode_out             = s_q.host_mode;
   assign host_bus_oe_out           = s_q.oe;
   assign soft_reset_out            = s_q.soft_pulse;
   assign subcode_block_address_out = s_q.sub_addr;                // [R11]
   assign serial_format_sel_out     = s_q.cfg[`DSCR_CFG_SERIAL_BIT];  // [R12]
   assign oversample_hi_out         = s_q.cfg[`DSCR_CFG_OVS_HI_BIT];  // [R13]
   assign oversample_lo_out         = s_q.cfg[`DSCR_CFG_OVS_LO_BIT];  // [R13]
   assign subcode_format_sel_out    = s_q.cfg[`DSCR_CFG_SUBFMT_BIT];  // [R14]
   assign subcode_port_enable_out   = s_q.cfg[`DSCR_CFG_SUBEN_BIT];   // [R15]
   assign subcode_raw_sel_out       = s_q.cfg[`DSCR_CFG_SUBRAW_BIT];  // [R16]
   assign ext_ram_test_out          = s_q.cfg[`DSCR_CFG_EXT_RAM_TEST_BIT]; // [R17]
   assign subcode_bit_tick_out      = s_q.tick;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_q);

   sequence soft_write_s;
      soft_wr ##1 1'b1;
   endsequence

   sequence status_read_s;
      stat_read && !decoder_interrupt_set_in;
   endsequence

   preview_map_a: assert property ( // [R1] [R2]
      mode_byte_valid_in && !soft_wr |=> s_q.preview[3] ==
         ((|$past(mode_byte_in[7:3])) | $past(erasure_flag_in)))
      else $error("preview top bit wrong");

   intr_clear_a: assert property ( // [R3]
      status_read_s |=> !decoder_interrupt_out)
      else $error("status read left interrupt set");

   intr_set_wins_a: assert property ( // [R3] [R4]
      decoder_interrupt_set_in && !soft_wr |=> decoder_interrupt_out && !s_q.invalid)
      else $error("interrupt set lost or flag not valid");

   status_bits_a: assert property ( // [R4] [R5]
      stat_read |=> s_axi_rvalid_out &&
         s_axi_rdata_out[7] == $past(s_q.invalid) &&
         s_axi_rdata_out[5] == $past(s_q.ecc) && s_axi_rdata_out[6] == 1'b0)
      else $error("status readback wrong");

   soft_reset_a: assert property ( // [R6] [R7]
      soft_write_s |-> s_q.cfg == 8'h00 && soft_reset_out &&
         host_mode_out == $past(s_q.wdata[2:0]))
      else $error("soft reset did not reinitialise");

   hw_mode_a: assert property ( // [R8]
      $rose(rst_n_q) |-> host_mode_out == 3'h7)
      else $error("host mode not 111 after reset");

   pins_hiz_a: assert property ( // [R9] [R10]
      !mode_known && s_q.hrd_s2 |=> !host_bus_oe_out)
      else $error("host pins driven in unknown mode");

   cfg_write_a: assert property ( // [R12] [R19]
      do_write && wsel == dscr_pkg::DSCR_SEL_CFG && s_q.wstrb[0] |=>
         s_q.cfg == ($past(s_q.wdata[7:0]) & 8'hFE))
      else $error("config write wrong");

   tick_none_a: assert property ( // [R18] [R15]
      bck_edge && s_q.cfg[6:5] == 2'h0 && s_q.cfg[3] && !soft_wr
         |=> subcode_bit_tick_out)
      else $error("missing subcode tick");

   tick_four_a: assert property ( // [R13] [R18]
      bck_edge && s_q.cfg[6:5] == 2'h2 && s_q.div_cnt != 2'h3 |=> !subcode_bit_tick_out)
      else $error("tick too early in four times mode");

endmodule

// ==== testbench/dscr_cpu_model.sv ====
/*
 * Sub-CPU model: AXI4-Lite master with one write task and one read task.
 * Assumes a slave with registered outputs on the same clock.
 */
module dscr_cpu_model (
   input  wire logic        clk_in,
   output logic      [7:0]  awaddr_out,
   output logic             awvalid_out,
   input  wire logic        awready_in,
   output logic      [31:0] wdata_out,
   output logic      [3:0]  wstrb_out,
   output logic             wvalid_out,
   input  wire logic        wready_in,
   input  wire logic [1:0]  bresp_in,
   input  wire logic        bvalid_in,
   output logic             bready_out,
   output logic      [7:0]  araddr_out,
   output logic             arvalid_out,
   input  wire logic        arready_in,
   input  wire logic [31:0] rdata_in,
   input  wire logic [1:0]  rresp_in,
   input  wire logic        rvalid_in,
   output logic             rready_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
      {awaddr_out, araddr_out, wdata_out, wstrb_out} = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] resp, output logic hung);
      @(posedge clk_in);
      awaddr_out <= a;
      wdata_out <= d;
      wstrb_out <= 4'hF;
      awvalid_out <= 1'b1;
      wvalid_out <= 1'b1;
      bready_out <= 1'b1;
      hung = 1'b1;
      for (int n = 0; n < 100 && hung; n++) begin
         @(posedge clk_in);
         if (awready_in) awvalid_out <= 1'b0;
         if (wready_in) wvalid_out <= 1'b0;
         if (bvalid_in) begin
            resp = bresp_in;
            bready_out <= 1'b0;
            hung = 1'b0;
         end
      end
   endtask

   // Read: address offered and dropped once taken, data and response kept on rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] resp, output logic hung);
      @(posedge clk_in);
      araddr_out <= a;
      arvalid_out <= 1'b1;
      rready_out <= 1'b1;
      hung = 1'b1;
      for (int n = 0; n < 100 && hung; n++) begin
         @(posedge clk_in);
         if (arready_in) arvalid_out <= 1'b0;
         if (rvalid_in) begin
            d = rdata_in;
            resp = rresp_in;
            rready_out <= 1'b0;
            hung = 1'b0;
         end
      end
   endtask
endmodule

// ==== testbench/dscr_regs_tb_top.sv ====
/*
 * Self-checking bench for the decoder status and configuration register bank.
 * Assumes the sub-CPU model owns the register bus; datapath pins are driven here.
 */
`include "dscr_cfg.svh"

module dscr_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, rst_n, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
   logic [7:0]  awa, ara, mbyte;
   logic [31:0] wd, rdat;
   logic [3:0]  ws;
   logic [1:0]  bresp, rresp;
   logic        eras, mval, dset, iset, ecc, hrd_n, serial_bit_clock, dint, oe, tick;
   logic [2:0]  hmode;
   logic [6:0]  cfgv;
   int          n_errors, compares, ticks, t0;
   logic [8:0]  pv [4] = '{9'h005, 9'h008, 9'h102, 9'h087};
   int          ocfg [4] = '{32'h28, 32'h48, 32'h20, 32'h08};
   int          otick [4] = '{4, 2, 0, 8};
   logic [9:0]  sba;

   dscr_cpu_model cpu (.clk_in(clk), .awaddr_out(awa), .awvalid_out(awv),
      .awready_in(awr), .wdata_out(wd), .wstrb_out(ws), .wvalid_out(wv), .wready_in(wrd),
      .bresp_in(bresp), .bvalid_in(bv), .bready_out(br), .araddr_out(ara),
      .arvalid_out(arv), .arready_in(arr), .rdata_in(rdat), .rresp_in(rresp),
      .rvalid_in(rv), .rready_out(rr));

   dscr_regs uut (.clock_in(clk), .arst_n_in(rst_n), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rr), .mode_byte_in(mbyte), .erasure_flag_in(eras),
      .mode_byte_valid_in(mval), .decoder_interrupt_set_in(dset),
      .regs_invalid_set_in(iset), .ecc_done_in(ecc), .host_read_strobe_n_in(hrd_n),
      .serial_bit_clock_in(serial_bit_clock), .decoder_interrupt_out(dint), .host_mode_out(hmode),
      .host_bus_oe_out(oe), .soft_reset_out(), .subcode_block_address_out(sba),
      .serial_format_sel_out(cfgv[6]), .oversample_hi_out(cfgv[5]),
      .oversample_lo_out(cfgv[4]), .subcode_format_sel_out(cfgv[3]),
      .subcode_port_enable_out(cfgv[2]), .subcode_raw_sel_out(cfgv[1]),
      .ext_ram_test_out(cfgv[0]), .subcode_bit_tick_out(tick));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and recovered bit counter
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (tick === 1'b1) ticks++;

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and shared checks
   task automatic end_sim();
      $display("Totals: compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic hang(input logic h);
      if (h) begin
         n_errors++;
         $display("CHECK FAILED at %0t: bus answer timed out", $time);
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      logic       h;
      cpu.wr(a, d, r, h);
      hang(h);
      chk(r, er, "write response");
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      logic        h;
      cpu.rd(a, d, r, h);
      hang(h);
      chk(r, er, "read response");
      if (er == `DSCR_RESP_OKAY) chk(d, exp, "read data");
   endtask

   // Preview nibble worked out from the mode byte and erasure flag
   function automatic logic [31:0] prev(input logic [7:0] b, input logic e);
      return {28'h0, (|b[7:3]) | e, b[2:0] | {3{e}}};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rst_n, mbyte, eras, mval, dset, iset, ecc, serial_bit_clock} = '0;
      hrd_n = 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(hmode, 3'h7, "host mode after reset");
      chk(oe, 1'b0, "pins after reset");
      rd(`DSCR_ADDR_IN_CFG, 32'h0, `DSCR_RESP_OKAY);
      $display("Test reset values done");
      for (int i = 1; i < 8; i++) begin
         wr(`DSCR_ADDR_IN_CFG, 32'h1 << i, `DSCR_RESP_OKAY);
         rd(`DSCR_ADDR_IN_CFG, 32'h1 << i, `DSCR_RESP_OKAY);
         chk(cfgv, (32'h1 << i) >> 1, "config outputs");
      end
      wr(`DSCR_ADDR_IN_CFG, 32'hFFFF_FF01, `DSCR_RESP_OKAY);
      rd(`DSCR_ADDR_IN_CFG, 32'h0, `DSCR_RESP_OKAY);
      wr(`DSCR_ADDR_SUB_ADDR, 32'hFFFF_FFFF, `DSCR_RESP_OKAY);
      rd(`DSCR_ADDR_SUB_ADDR, 32'h3FF, `DSCR_RESP_OKAY);
      chk(sba, 10'h3FF, "subcode address output");
      rd(8'h20, 32'h0, `DSCR_RESP_SLVERR);
      wr(8'h20, 32'hFF, `DSCR_RESP_SLVERR);
      $display("Test config and address done");
      foreach (pv[k]) begin
         {eras, mbyte} <= pv[k];
         mval <= 1'b1;
         @(posedge clk);
         mval <= 1'b0;
         rd(`DSCR_ADDR_PREVIEW, prev(mbyte, eras), `DSCR_RESP_OKAY);
      end
      $display("Test preview done");
      dset <= 1'b1;
      ecc <= 1'b1;
      @(posedge clk);
      dset <= 1'b0;
      repeat (2) @(posedge clk);
      chk(dint, 1'b1, "interrupt raised");
      rd(`DSCR_ADDR_STATUS, 32'h20, `DSCR_RESP_OKAY);
      chk(dint, 1'b0, "interrupt cleared by read");
      iset <= 1'b1;
      ecc <= 1'b0;
      @(posedge clk);
      iset <= 1'b0;
      rd(`DSCR_ADDR_STATUS, 32'h80, `DSCR_RESP_OKAY);
      $display("Test status done");
      for (int m = 0; m < 4; m++) begin
         wr(`DSCR_ADDR_IN_CFG, 32'hFE, `DSCR_RESP_OKAY);
         wr(`DSCR_ADDR_SOFT_RESET, m, `DSCR_RESP_OKAY);
         repeat (2) @(posedge clk);
         chk(hmode, m, "host mode");
         chk(oe, m != 3, "pin enable");
         rd(`DSCR_ADDR_IN_CFG, 32'h0, `DSCR_RESP_OKAY);
      end
      hrd_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk(oe, 1'b1, "strobe low drives pins");
      hrd_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(oe, 1'b0, "strobe high releases pins");
      $display("Test host mode done");
      foreach (ocfg[k]) begin
         wr(`DSCR_ADDR_IN_CFG, ocfg[k], `DSCR_RESP_OKAY);
         t0 = ticks;
         repeat (8) begin
            serial_bit_clock <= 1'b1;
            repeat (2) @(posedge clk);
            serial_bit_clock <= 1'b0;
            repeat (2) @(posedge clk);
         end
         repeat (4) @(posedge clk);
         chk(ticks - t0, otick[k], "bit ticks");
      end
      $display("Test bit clock done");
      end_sim();
   end
endmodule
